// ### inc/lhsup_cfg.svh
// Offsets, field positions, reset values and timing counts of the fallback supervisor.
`ifndef LHSUP_CFG_SVH
`define LHSUP_CFG_SVH
`define LHSUP_ADDR_CONTROL 8'h3C
`define LHSUP_ADDR_STATUS 8'h54
`define LHSUP_ADDR_DIAG 8'h5F
`define LHSUP_CTRL_PAT_HI 6
`define LHSUP_CTRL_PAT_LO 4
`define LHSUP_CTRL_TSEL_HI 3
`define LHSUP_CTRL_TSEL_LO 1
`define LHSUP_STATUS_ACTIVE_BIT 3
`define LHSUP_NV_DISABLE_BIT 2
`define LHSUP_PAT_REFRESH 3'b111
`define LHSUP_PAT_STEP1 3'b001
`define LHSUP_PAT_STEP2 3'b010
`define LHSUP_PAT_STEP3 3'b100
`define LHSUP_CTRL_RESET 8'h00
`define LHSUP_CLK_HZ 50000000
`define LHSUP_TIMEOUT_BASE_NS 5409600
`define LHSUP_TIMEOUT_BASE_CYC ((`LHSUP_TIMEOUT_BASE_NS * 64'd50) / 64'd1000)
`define LHSUP_FILTER_NS 20000
`define LHSUP_FILTER_CYC ((`LHSUP_FILTER_NS * 50) / 1000)
`define LHSUP_RESTART_OT 0
`define LHSUP_RESTART_UV 1
`define LHSUP_RESTART_OV 2
`endif

// ### inc/lhsup_pkg.sv
// Types shared by the fallback supervisor files.
package lhsup_pkg;
    typedef enum logic [1:0] {
        LHSUP_RUN,
        LHSUP_FALLBACK,
        LHSUP_SILENT
    } lhsup_mode_type;
    typedef enum logic [1:0] {
        LHSUP_EXIT_IDLE,
        LHSUP_EXIT_ONE,
        LHSUP_EXIT_TWO
    } lhsup_exit_type;
endpackage

// ### design/lhsup_filter.sv
// Debounce filter for one output-regulated status bit.
`include "lhsup_cfg.svh"
module lhsup_filter
    import lhsup_pkg::*;
#(
    parameter int FILTER_CYC = `LHSUP_FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic inWindow,
    output logic regulated
);
    logic [15:0] count_reg, count_next;
    logic flag_reg, flag_next;
    logic sync1_reg, sync2_reg;

    always_comb begin
        count_next = count_reg;
        flag_next = flag_reg;
        if (sync2_reg == flag_reg) begin
            count_next = 16'h0000;
        end else if (count_reg >= 16'(FILTER_CYC)) begin
            flag_next = sync2_reg;
            count_next = 16'h0000;
        end else begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= 16'h0000;
            flag_reg <= 1'b0;
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (clkEn) begin
            sync1_reg <= inWindow;
            sync2_reg <= sync1_reg;
            count_reg <= count_next;
            flag_reg <= flag_next;
        end
    end
    assign regulated = flag_reg;

    chk_set_after_filter: assert property (@(posedge clk) disable iff (rst)
        (clkEn && !flag_reg && flag_next) |-> count_reg >= 16'(FILTER_CYC))
        else $error("regulated flag changed before filter time");
    chk_clear_after_filter: assert property (@(posedge clk) disable iff (rst)
        $fell(flag_reg) |-> !$past(sync2_reg))
        else $error("regulated flag cleared while inside window");
endmodule

// ### design/limp_home_supervisor.sv
// Fallback supervisor: refresh timer, fallback mode, exit sequence and fail-silent restart.
`include "lhsup_cfg.svh"
// Function
// - Set regulated bit only after output stays in window beyond filter time.
// - Clear regulated bit after output stays outside window beyond filter time.
// - Fail-silent state switches off all converter outputs.
// - Default restart: stay silent until enable pin cycles; host reconfigures.
// - Automatic restart leaves silent state when error clears, keeping configuration.
// - Per-source stored restart choice for over-temperature, undervoltage, overvoltage.
// - Lost refresh in normal operation enters fallback and loads stored settings.
// - Stored-configuration use mode keeps all converter outputs disabled.
// - Status register 54h bit 3 shows fallback mode.
// - Stored disable bit 2 stops the timer from ever triggering fallback.
// - Writing pattern 111 to register 3Ch restarts the timeout timer.
// - Timer expiry enters fallback; timeout doubles per code from 5.4096 ms.
// - In fallback only the control register is writable; others read-only.
// - Exit fallback by writing patterns 001, 010, 100 in order.
// - After complete exit, register writes are obeyed again immediately.
// - Exit keeps the register contents loaded for fallback mode.
// - Back in normal operation, full register access is restored.
// - Control register: pattern bits 6:4, timeout select bits 3:1, 7 and 0 reserved.
// - Fallback runs the same converter functions from loaded settings.
// - Clearing an error flag by diagnostic write does not release fail-silent.
module limp_home_supervisor
    import lhsup_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int CFG_W = 8,
    parameter longint TIMEOUT_BASE_CYC = `LHSUP_TIMEOUT_BASE_CYC,
    parameter int FILTER_CYC = `LHSUP_FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [DATA_W-1:0] regWData,
    output logic [DATA_W-1:0] regRData,
    output logic writeAllowed,
    input wire logic [CFG_W-1:0] workCfg,
    input wire logic [CFG_W-1:0] nvFallbackCfg,
    input wire logic [7:0] nvMultiContent,
    input wire logic [2:0] nvAutoRestart,
    input wire logic nvUseMode,
    input wire logic overtempError,
    input wire logic supplyUnderFlag,
    input wire logic supplyOverFlag,
    input wire logic output1InWindow,
    input wire logic output2InWindow,
    output logic output1Regulated,
    output logic output2Regulated,
    output logic fallbackActive,
    output logic failSilent,
    output logic outputsEnable,
    output logic loadFallbackCfg,
    output logic [CFG_W-1:0] fallbackCfg
);
    lhsup_mode_type mode_reg, mode_next;
    lhsup_exit_type exit_reg, exit_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [39:0] timer_reg, timer_next;
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic [2:0] latch_reg, latch_next;
    logic load_reg, load_next;
    logic [2:0] errSync1_reg, errSync2_reg;
    logic nvSync1_reg, nvSync2_reg;
    logic [2:0] errNow;
    logic [2:0] pattern;
    logic [2:0] tsel;
    logic ctrlWrite;
    logic supervise;
    logic [39:0] timeoutCyc;
    logic expired;
    logic blocking;

    // ------------------------------------------------------------------
    // Output regulation filters
    // ------------------------------------------------------------------
    lhsup_filter #(.FILTER_CYC(FILTER_CYC)) filter1 (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .inWindow(output1InWindow),
        .regulated(output1Regulated)
    );
    lhsup_filter #(.FILTER_CYC(FILTER_CYC)) filter2 (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .inWindow(output2InWindow),
        .regulated(output2Regulated)
    );

    // ------------------------------------------------------------------
    // Decode and timer
    // ------------------------------------------------------------------
    assign errNow = errSync2_reg;
    assign pattern = regWData[`LHSUP_CTRL_PAT_HI:`LHSUP_CTRL_PAT_LO];
    assign tsel = ctrl_reg[`LHSUP_CTRL_TSEL_HI:`LHSUP_CTRL_TSEL_LO];
    assign ctrlWrite = regWrite && (regAddr == `LHSUP_ADDR_CONTROL);
    assign supervise = !nvMultiContent[`LHSUP_NV_DISABLE_BIT];
    assign timeoutCyc = 40'(TIMEOUT_BASE_CYC) << tsel;
    assign expired = supervise && (timer_reg >= timeoutCyc - 40'h0000_0000_01);
    assign blocking = (mode_reg == LHSUP_FALLBACK);

    always_comb begin
        mode_next = mode_reg;
        exit_next = exit_reg;
        ctrl_next = ctrl_reg;
        timer_next = timer_reg;
        cfg_next = cfg_reg;
        latch_next = latch_reg;
        load_next = 1'b0;
        if (ctrlWrite) begin
            ctrl_next = {1'b0, regWData[6:1], 1'b0};
        end
        if (mode_reg == LHSUP_RUN && ctrlWrite && pattern == `LHSUP_PAT_REFRESH) begin
            timer_next = 40'h00_0000_0000;
        end else if (mode_reg == LHSUP_RUN && supervise) begin
            timer_next = timer_reg + 40'h00_0000_0001;
        end else begin
            timer_next = 40'h00_0000_0000;
        end
        case (mode_reg)
            LHSUP_RUN: begin
                if (expired) begin
                    mode_next = LHSUP_FALLBACK;
                    cfg_next = nvFallbackCfg;
                    load_next = 1'b1;
                    exit_next = LHSUP_EXIT_IDLE;
                end
            end
            LHSUP_FALLBACK: begin
                if (ctrlWrite) begin
                    case (exit_reg)
                        LHSUP_EXIT_IDLE: begin
                            exit_next = (pattern == `LHSUP_PAT_STEP1) ? LHSUP_EXIT_ONE
                                : LHSUP_EXIT_IDLE;
                        end
                        LHSUP_EXIT_ONE: begin
                            exit_next = (pattern == `LHSUP_PAT_STEP2) ? LHSUP_EXIT_TWO
                                : LHSUP_EXIT_IDLE;
                        end
                        LHSUP_EXIT_TWO: begin
                            exit_next = LHSUP_EXIT_IDLE;
                            if (pattern == `LHSUP_PAT_STEP3) begin
                                mode_next = LHSUP_RUN;
                            end
                        end
                        default: begin
                            exit_next = LHSUP_EXIT_IDLE;
                        end
                    endcase
                end
            end
            LHSUP_SILENT: begin
                if ((latch_reg & ~nvAutoRestart) == 3'b000 && errNow == 3'b000) begin
                    mode_next = LHSUP_RUN;
                end
            end
            default: begin
                mode_next = LHSUP_RUN;
            end
        endcase
        if (errNow != 3'b000) begin
            mode_next = LHSUP_SILENT;
            latch_next = latch_reg | errNow;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= LHSUP_RUN;
            exit_reg <= LHSUP_EXIT_IDLE;
            ctrl_reg <= `LHSUP_CTRL_RESET;
            timer_reg <= 40'h00_0000_0000;
            cfg_reg <= '0;
            latch_reg <= 3'b000;
            load_reg <= 1'b0;
            errSync1_reg <= 3'b000;
            errSync2_reg <= 3'b000;
            nvSync1_reg <= 1'b0;
            nvSync2_reg <= 1'b0;
        end else if (clkEn) begin
            errSync1_reg <= {supplyOverFlag, supplyUnderFlag, overtempError};
            errSync2_reg <= errSync1_reg;
            nvSync1_reg <= nvUseMode;
            nvSync2_reg <= nvSync1_reg;
            mode_reg <= mode_next;
            exit_reg <= exit_next;
            ctrl_reg <= ctrl_next;
            timer_reg <= timer_next;
            cfg_reg <= cfg_next;
            latch_reg <= latch_next;
            load_reg <= load_next;
        end
    end

    // ------------------------------------------------------------------
    // Register read and outputs
    // ------------------------------------------------------------------
    always_comb begin
        regRData = '0;
        if (regAddr == `LHSUP_ADDR_STATUS) begin
            regRData[`LHSUP_STATUS_ACTIVE_BIT] = blocking;
        end else if (regAddr == `LHSUP_ADDR_CONTROL) begin
            regRData = DATA_W'(ctrl_reg);
        end
    end
    assign writeAllowed = !blocking || (regAddr == `LHSUP_ADDR_CONTROL);
    assign fallbackActive = blocking;
    assign failSilent = (mode_reg == LHSUP_SILENT);
    assign outputsEnable = !failSilent && !nvSync2_reg;
    assign loadFallbackCfg = load_reg;
    assign fallbackCfg = cfg_reg;

    chk_expiry_enters: assert property (@(posedge clk) disable iff (rst)
        (clkEn && mode_reg == LHSUP_RUN && expired && errNow == 3'b000)
        |=> (mode_reg == LHSUP_FALLBACK && loadFallbackCfg && fallbackCfg == $past(nvFallbackCfg)))
        else $error("timer expiry did not enter fallback with stored settings");
    chk_refresh_clears: assert property (@(posedge clk) disable iff (rst)
        (clkEn && mode_reg == LHSUP_RUN && ctrlWrite && pattern == `LHSUP_PAT_REFRESH)
        |=> timer_reg == 40'h00_0000_0000)
        else $error("refresh write did not restart the timer");
    chk_disable_stops: assert property (@(posedge clk) disable iff (rst)
        (clkEn && mode_reg == LHSUP_RUN && !supervise) |=> mode_reg != LHSUP_FALLBACK)
        else $error("disabled supervision entered fallback");
    chk_status_bit: assert property (@(posedge clk) disable iff (rst)
        regAddr == `LHSUP_ADDR_STATUS
        |-> regRData[`LHSUP_STATUS_ACTIVE_BIT] == (mode_reg == LHSUP_FALLBACK))
        else $error("status bit does not follow fallback mode");
    chk_write_lock: assert property (@(posedge clk) disable iff (rst)
        (fallbackActive && regAddr != `LHSUP_ADDR_CONTROL) |-> !writeAllowed)
        else $error("write allowed to locked register in fallback");
    chk_exit_seq: assert property (@(posedge clk) disable iff (rst)
        (clkEn && mode_reg == LHSUP_FALLBACK && ctrlWrite && exit_reg == LHSUP_EXIT_ONE
        && pattern != `LHSUP_PAT_STEP2 && errNow == 3'b000) |=> exit_reg == LHSUP_EXIT_IDLE)
        else $error("wrong exit write did not abandon the sequence");
    chk_exit_keeps: assert property (@(posedge clk) disable iff (rst)
        ($past(mode_reg) == LHSUP_FALLBACK && mode_reg == LHSUP_RUN)
        |-> (fallbackCfg == $past(fallbackCfg) && writeAllowed))
        else $error("exit lost loaded settings or access");
    chk_silent_off: assert property (@(posedge clk) disable iff (rst)
        failSilent |-> !outputsEnable)
        else $error("outputs enabled in fail-silent state");
    chk_manual_hold: assert property (@(posedge clk) disable iff (rst)
        (failSilent && (latch_reg & ~nvAutoRestart) != 3'b000) |=> failSilent)
        else $error("left fail-silent without enable cycling");
endmodule

// ### tb/lhsup_host_model.sv
// Host model that refreshes the fallback timer at a fixed period.
module lhsup_host_model #(
    parameter int PERIOD = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] timeoutSel,
    output logic hostWrite,
    output logic [7:0] hostAddr,
    output logic [7:0] hostData
);
    timeunit 1ns;
    timeprecision 1ns;
    int count;
    // ----------------------------------------
    // Refresh writes
    // ----------------------------------------
    assign hostAddr = 8'h3C;
    assign hostData = {1'h0, 3'h7, timeoutSel, 1'h0};
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            count <= 0;
            hostWrite <= 1'h0;
        end else if (count == PERIOD - 1) begin
            count <= 0;
            hostWrite <= 1'h1;
        end else begin
            count <= count + 1;
            hostWrite <= 1'h0;
        end
    end
endmodule

// ### tb/test_limp_home_supervisor.sv
// Self-checking testbench of the fallback supervisor.
module test_limp_home_supervisor;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, tbWrite, hostRun, hostWrite, useMode, win1, win2;
    logic [7:0] tbAddr, tbData, hostAddr, hostData, nvMulti, regRData, rdv;
    logic [2:0] nvAuto, errs;
    logic writeAllowed, o1, o2, fallbackActive, failSilent, outputsEnable;
    logic [7:0] fallbackCfg, nvCfg;
    logic clkEn, loadCfg;
    int fails = 0;
    int testsRun = 0;
    // ----------------------------------------
    // Instances
    // ----------------------------------------
    limp_home_supervisor #(.TIMEOUT_BASE_CYC(20), .FILTER_CYC(4)) limp_home_supervisor_i (
        .clk(clk), .rst(rst), .clkEn(clkEn), .regWrite(tbWrite | hostWrite),
        .regAddr(hostWrite ? hostAddr : tbAddr), .regWData(hostWrite ? hostData : tbData),
        .regRData(regRData), .writeAllowed(writeAllowed), .workCfg(8'h00),
        .nvFallbackCfg(nvCfg), .nvMultiContent(nvMulti), .nvAutoRestart(nvAuto),
        .nvUseMode(useMode), .overtempError(errs[0]), .supplyUnderFlag(errs[1]),
        .supplyOverFlag(errs[2]), .output1InWindow(win1), .output2InWindow(win2),
        .output1Regulated(o1), .output2Regulated(o2), .fallbackActive(fallbackActive),
        .failSilent(failSilent), .outputsEnable(outputsEnable), .loadFallbackCfg(loadCfg),
        .fallbackCfg(fallbackCfg));
    lhsup_host_model lhsup_host_model_i (
        .clk(clk), .rst(rst), .run(hostRun), .timeoutSel(3'h0),
        .hostWrite(hostWrite), .hostAddr(hostAddr), .hostData(hostData));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        testsRun++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        tbWrite <= 1'h1;
        tbAddr <= a;
        tbData <= d;
        @(posedge clk);
        tbWrite <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        tbAddr <= a;
        #1;
        rdv = regRData;
    endtask
    task automatic exit_seq();
        wr(8'h3C, 8'h10);
        wr(8'h3C, 8'h20);
        wr(8'h3C, 8'h40);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'h1;
        clkEn = 1'h1;
        nvCfg = 8'hA5;
        tbWrite = 1'h0;
        tbAddr = 8'h00;
        tbData = 8'h00;
        hostRun = 1'h0;
        nvMulti = 8'h00;
        nvAuto = 3'h0;
        errs = 3'h0;
        useMode = 1'h0;
        win1 = 1'h0;
        win2 = 1'h0;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        hostRun <= 1'h1;
        rd(8'h54);
        check(rdv, 8'h00, "status after reset");
        check(writeAllowed, 1'h1, "write access after reset");
        cyc(80);
        check(fallbackActive, 1'h0, "fallback despite refresh");
        $display("test refresh done");
        hostRun <= 1'h0;
        wr(8'h3C, 8'h70);
        cyc(19);
        check(fallbackActive, 1'h0, "fallback too early");
        cyc(1);
        check(fallbackActive, 1'h1, "no fallback on expiry");
        check(loadCfg, 1'h1, "settings load pulse missing");
        rd(8'h54);
        check(rdv, 8'h08, "status in fallback");
        check(loadCfg, 1'h0, "settings load pulse too long");
        check(fallbackCfg, 8'hA5, "fallback settings not loaded");
        rd(8'h20);
        check(writeAllowed, 1'h0, "write allowed in fallback");
        rd(8'h3C);
        check(writeAllowed, 1'h1, "control locked in fallback");
        wr(8'h3C, 8'h70);
        wr(8'h3C, 8'h10);
        wr(8'h3C, 8'h40);
        wr(8'h3C, 8'h20);
        wr(8'h3C, 8'h40);
        check(fallbackActive, 1'h1, "broken sequence accepted");
        clkEn <= 1'h0;
        exit_seq();
        check(fallbackActive, 1'h1, "state changed with clock enable low");
        clkEn <= 1'h1;
        exit_seq();
        check(fallbackActive, 1'h0, "exit sequence ignored");
        check(fallbackCfg, 8'hA5, "settings changed on exit");
        rd(8'h20);
        check(writeAllowed, 1'h1, "writes refused after exit");
        $display("test fallback done");
        wr(8'h3C, 8'hF3);
        nvCfg <= 8'h5A;
        rd(8'h3C);
        check(rdv & 8'h81, 8'h00, "reserved bits read back");
        check(rdv & 8'h0E, 8'h02, "timeout select read back");
        cyc(38);
        check(fallbackActive, 1'h0, "longer timeout too short");
        cyc(1);
        check(fallbackActive, 1'h1, "longer timeout missed");
        check(fallbackCfg, 8'h5A, "second fallback settings not loaded");
        exit_seq();
        nvMulti <= 8'h04;
        cyc(120);
        check(fallbackActive, 1'h0, "supervision not disabled");
        $display("test timeout done");
        for (int i = 0; i < 3; i++) begin
            nvAuto <= 3'h0;
            errs[i] <= 1'h1;
            cyc(6);
            check(failSilent, 1'h1, "no silent state on error");
            check(outputsEnable, 1'h0, "outputs on while silent");
            errs <= 3'h0;
            cyc(8);
            check(failSilent, 1'h1, "silent state left without enable cycle");
            rst <= 1'h1;
            cyc(2);
            rst <= 1'h0;
            cyc(1);
            check(failSilent, 1'h0, "silent after enable cycle");
            nvAuto <= 3'(1 << i);
            errs[i] <= 1'h1;
            cyc(6);
            check(failSilent, 1'h1, "no silent state on error");
            errs <= 3'h0;
            cyc(6);
            check(failSilent, 1'h0, "no automatic restart");
            check(outputsEnable, 1'h1, "outputs off after restart");
        end
        $display("test restart done");
        useMode <= 1'h1;
        cyc(4);
        check(outputsEnable, 1'h0, "outputs on in use mode");
        useMode <= 1'h0;
        cyc(4);
        check(outputsEnable, 1'h1, "outputs off after use mode");
        win1 <= 1'h1;
        win2 <= 1'h1;
        cyc(6);
        check({o1, o2}, 2'h0, "regulated set too early");
        cyc(1);
        check({o1, o2}, 2'h3, "regulated not set");
        win1 <= 1'h0;
        cyc(6);
        check({o1, o2}, 2'h3, "regulated cleared too early");
        cyc(1);
        check({o1, o2}, 2'h1, "regulated not cleared");
        $display("test outputs done");
        finish_test();
    end
endmodule
